// File: ace_pkg.sv
// constants, state encoding and byte-level helpers for the crypto engine
// assumes a single peripheral clock; shared by ace_mem, ace_round and ace_engine
package ace_pkg;
   // register indices; the byte address on the bus is four times the index
   localparam logic [2:0] IDX_CTRL = 3'h0;
   localparam logic [2:0] IDX_STATUS = 3'h1;
   localparam logic [2:0] IDX_STATE = 3'h2;
   localparam logic [2:0] IDX_KEY = 3'h3;
   localparam logic [2:0] IDX_INTCTRL = 3'h4;
   // field positions
   localparam int CTRL_START = 7;
   localparam int CTRL_AUTO = 6;
   localparam int CTRL_RESET = 5;
   localparam int CTRL_DECRYPT = 4;
   localparam int CTRL_XOR = 2;
   localparam int STAT_ERROR = 7;
   localparam int STAT_DONE = 0;
   // reset values
   localparam logic WAIT_RST = 1'b1;
   localparam logic [1:0] INTLVL_RST = 2'h0;
   localparam logic [3:0] PTR_RST = 4'h0;
   localparam logic [127:0] BLOCK_RST = 128'h0;
   // timing: a run lasts 375 clock cycles from the start edge
   localparam logic [8:0] RUN_CYCLES = 9'h177;
   localparam logic [8:0] RUN_LAST = RUN_CYCLES - 9'h001;
   localparam logic [3:0] NUM_ROUNDS = 4'ha;
   typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_RUN = 2'b10} ace_state_t;
   localparam logic [2047:0] SBOX = {
      256'h637c777bf26b6fc53001672bfed7ab76ca82c97dfa5947f0add4a2af9ca472c0,
      256'hb7fd9326363ff7cc34a5e5f171d8311504c723c31896059a071280e2eb27b275,
      256'h09832c1a1b6e5aa0523bd6b329e32f8453d100ed20fcb15b6acbbe394a4c58cf,
      256'hd0efaafb434d338545f9027f503c9fa851a3408f929d38f5bcb6da2110fff3d2,
      256'hcd0c13ec5f974417c4a77e3d645d197360814fdc222a908846eeb814de5e0bdb,
      256'he0323a0a4906245cc2d3ac629195e479e7c8376d8dd54ea96c56f4ea657aae08,
      256'hba78252e1ca6b4c6e8dd741f4bbd8b8a703eb5664803f60e613557b986c11d9e,
      256'he1f8981169d98e949b1e87e9ce5528df8ca1890dbfe6426841992d0fb054bb16};
   localparam logic [2047:0] INV_SBOX = {
      256'h52096ad53036a538bf40a39e81f3d7fb7ce339829b2fff87348e4344c4dee9cb,
      256'h547b9432a6c2233dee4c950b42fac34e082ea16628d924b2765ba2496d8bd125,
      256'h72f8f66486689816d4a45ccc5d65b6926c704850fdedb9da5e154657a78d9d84,
      256'h90d8ab008cbcd30af7e45805b8b34506d02c1e8fca3f0f02c1afbd0301138a6b,
      256'h3a9111414f67dcea97f2cfcef0b4e67396ac7422e7ad3585e2f937e81c75df6e,
      256'h47f11a711d29c5896fb7620eaa18be1bfc563e4bc6d279209adbc0fe78cd5af4,
      256'h1fdda8338807c731b11210592780ec5f60517fa919b54a0d2de57a9f93c99cef,
      256'ha0e03b4dae2af5b0c8ebbb3c83539961172b047eba77d626e169146355210c7d};

   function automatic logic [7:0] sbox(input logic [7:0] x, input logic inv);
      int p;
      p = (255 - int'(x)) * 8;
      return inv ? INV_SBOX[p +: 8] : SBOX[p +: 8];
   endfunction : sbox

   function automatic logic [7:0] xtime(input logic [7:0] b);
      return {b[6:0], 1'b0} ^ (b[7] ? 8'h1b : 8'h00);
   endfunction : xtime

   function automatic logic [7:0] rcon(input logic [3:0] r);
      case (r)
         4'h1: return 8'h01;
         4'h2: return 8'h02;
         4'h3: return 8'h04;
         4'h4: return 8'h08;
         4'h5: return 8'h10;
         4'h6: return 8'h20;
         4'h7: return 8'h40;
         4'h8: return 8'h80;
         4'h9: return 8'h1b;
         4'ha: return 8'h36;
         default: return 8'h00;
      endcase
   endfunction : rcon
endpackage : ace_pkg

// File: ace_mem.sv
// 16 x 8-bit memory with registered read data and a whole-block port
// assumes the caller never asserts loadAll and wrEn in the same cycle
`timescale 1ns/1ps
module ace_mem
   import ace_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clr,
   input wire logic wrEn,
   input wire logic xorEn,
   input wire logic [3:0] wrAddr,
   input wire logic [7:0] wrData,
   input wire logic [3:0] rdAddr,
   input wire logic loadAll,
   input wire logic [127:0] loadData,
   output logic [7:0] rdData,
   output logic [127:0] allData
);
   logic [127:0] next_allData;
   logic [7:0] next_rdData;

   always_comb begin
      next_allData = allData;
      if (clr) begin
         next_allData = BLOCK_RST;
      end else if (loadAll) begin
         next_allData = loadData;
      end else if (wrEn) begin
         next_allData[{wrAddr, 3'b000} +: 8] = xorEn ?
            (allData[{wrAddr, 3'b000} +: 8] ^ wrData) : wrData;
      end
      // read data follow the pointer one cycle late
      next_rdData = clr ? 8'h00 : allData[{rdAddr, 3'b000} +: 8];
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         allData <= BLOCK_RST;
         rdData <= 8'h00;
      end else begin
         allData <= next_allData;
         rdData <= next_rdData;
      end
   end
endmodule : ace_mem

// File: ace_round.sv
// one cipher round and one key schedule step, purely combinational
// byte i of a block sits at bits [8i+7:8i], column-major order
`timescale 1ns/1ps
module ace_round
   import ace_pkg::*;
(
   input wire logic [127:0] stIn,
   input wire logic [127:0] keyIn,
   input wire logic [3:0] round,
   input wire logic decrypt,
   output logic [127:0] stOut,
   output logic [127:0] keyOut
);
   logic [127:0] sb, pre, mixed, kFwd, kBwd;
   logic [31:0] t, p3;
   logic [7:0] rc;
   logic last;

   function automatic logic [7:0] gmul(input logic [7:0] a,
                                       input logic [3:0] m);
      logic [7:0] a2, a4, a8;
      a2 = xtime(a);
      a4 = xtime(a2);
      a8 = xtime(a4);
      return (m[0] ? a : 8'h00) ^ (m[1] ? a2 : 8'h00) ^
             (m[2] ? a4 : 8'h00) ^ (m[3] ? a8 : 8'h00);
   endfunction : gmul

   function automatic logic [31:0] mixCol(input logic [31:0] c,
                                          input logic inv);
      logic [31:0] r;
      logic [3:0] m0, m1, m2, m3;
      m0 = inv ? 4'he : 4'h2;
      m1 = inv ? 4'hb : 4'h3;
      m2 = inv ? 4'hd : 4'h1;
      m3 = inv ? 4'h9 : 4'h1;
      for (int i = 0; i < 4; i++) begin
         r[8*i +: 8] = gmul(c[8*i +: 8], m0) ^
            gmul(c[8*((i+1)%4) +: 8], m1) ^
            gmul(c[8*((i+2)%4) +: 8], m2) ^
            gmul(c[8*((i+3)%4) +: 8], m3);
      end
      return r;
   endfunction : mixCol

   function automatic logic [31:0] subRot(input logic [31:0] w);
      logic [31:0] r;
      r = {w[7:0], w[31:8]};
      for (int i = 0; i < 4; i++) begin
         r[8*i +: 8] = sbox(r[8*i +: 8], 1'b0);
      end
      return r;
   endfunction : subRot

   always_comb begin
      last = (round == NUM_ROUNDS);
      // decryption steps walk the schedule from round ten down to one
      rc = rcon(decrypt ? 4'(4'hb - round) : round);
      // forward schedule step
      t = subRot(keyIn[127:96]) ^ {24'h0, rc};
      kFwd[31:0] = keyIn[31:0] ^ t;
      kFwd[63:32] = keyIn[63:32] ^ kFwd[31:0];
      kFwd[95:64] = keyIn[95:64] ^ kFwd[63:32];
      kFwd[127:96] = keyIn[127:96] ^ kFwd[95:64];
      // backward schedule step
      p3 = keyIn[127:96] ^ keyIn[95:64];
      kBwd[127:96] = p3;
      kBwd[95:64] = keyIn[95:64] ^ keyIn[63:32];
      kBwd[63:32] = keyIn[63:32] ^ keyIn[31:0];
      kBwd[31:0] = keyIn[31:0] ^ subRot(p3) ^ {24'h0, rc};
      keyOut = decrypt ? kBwd : kFwd;
      // row shift and byte substitution commute
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            sb[8*(4*c+r) +: 8] = sbox(decrypt ?
               stIn[8*(4*((c+4-r)%4)+r) +: 8] :
               stIn[8*(4*((c+r)%4)+r) +: 8], decrypt);
         end
      end
      pre = decrypt ? (sb ^ keyOut) : sb;
      for (int c = 0; c < 4; c++) begin
         mixed[32*c +: 32] = mixCol(pre[32*c +: 32], decrypt);
      end
      stOut = last ? pre : mixed;
      if (!decrypt) begin
         stOut = stOut ^ keyOut;
      end
   end
endmodule : ace_round

// File: ace_engine.sv
// top of the block cipher engine: Avalon-MM slave, control, run sequencer
// assumes a master that holds each request until waitrequest is seen low
//
// Function
// - compute standard block cipher, 128-bit block with 128-bit key
// - result is written back 375 clock cycles after start
// - software bit chooses encryption or decryption
// - in xor mode a state write combines with the stored byte
// - completion sets the done flag and, if enabled, the interrupt
// - key and state memories are sixteen bytes, only via access registers
// - each memory has its own read and write pointer, reset zero
// - read advances the read pointer, write advances the write pointer
// - any control register access clears all four pointers
// - pointers wrap to zero after sixteen accesses
// - pointers are not visible to software
// - in xor mode a write advances both pointers of that memory
// - key and state accesses are ignored during a run
// - state memory holds input and final block, intermediate rounds stay in stReg
// - key memory ends as last subkey or recovered cipher key
// - a finished run pulses the dma trigger
// - auto mode starts a run once the state memory is full
// - start reads one while running, clears at end, zero aborts
// - done clears on a state read or when written with one
// - error on bad access count at start or control access in run
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module ace_engine
   import ace_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [4:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic irq,
   output logic dmaTrig
);
   ace_state_t state, next_state;
   logic [3:0] round, next_round;
   logic [8:0] cycCnt, next_cycCnt;
   logic [127:0] stReg, next_stReg, keyReg, next_keyReg;
   logic [3:0] kRd, next_kRd, kWr, next_kWr, sRd, next_sRd, sWr, next_sWr;
   logic [3:0] accCnt, next_accCnt;
   logic autoEn, next_autoEn, decrypt, next_decrypt, xorMode, next_xorMode;
   logic [1:0] intLvl, next_intLvl;
   logic errorFlag, next_errorFlag, doneFlag, next_doneFlag;
   logic swRst, next_swRst;
   logic [31:0] next_readdata;
   logic next_waitrequest, next_irq, next_dmaTrig;
   logic [2:0] idx;
   logic acc, wrAcc, running, finish, startReq;
   logic ctrlAcc, stAccRaw, keyAccRaw, stAcc, keyAcc, stWrite, keyWrite;
   logic [7:0] sMemRd, kMemRd;
   logic [127:0] sMemAll, kMemAll, rStOut, rKeyOut;

   assign idx = address[4:2];
   assign acc = (read | write) & waitrequest;
   assign wrAcc = acc & write & byteenable[0];
   assign running = (state == ST_RUN);
   assign finish = running && (cycCnt == RUN_LAST);
   assign ctrlAcc = acc && (idx == IDX_CTRL);
   assign stAccRaw = acc && (idx == IDX_STATE);
   assign keyAccRaw = acc && (idx == IDX_KEY);
   assign stAcc = stAccRaw && !running;
   assign keyAcc = keyAccRaw && !running;
   assign stWrite = stAcc && write && byteenable[0];
   assign keyWrite = keyAcc && write && byteenable[0];

   // memories only reachable through the byte ports
   ace_mem u_stateMem (
      .clk(clk),
      .sys_rst(sys_rst),
      .clr(swRst),
      .wrEn(stWrite),
      .xorEn(xorMode),
      .wrAddr(sWr),
      .wrData(writedata[7:0]),
      .rdAddr(sRd),
      .loadAll(finish),
      .loadData(stReg),
      .rdData(sMemRd),
      .allData(sMemAll)
   );

   ace_mem u_keyMem (
      .clk(clk),
      .sys_rst(sys_rst),
      .clr(swRst),
      .wrEn(keyWrite),
      .xorEn(1'b0),
      .wrAddr(kWr),
      .wrData(writedata[7:0]),
      .rdAddr(kRd),
      .loadAll(finish),
      .loadData(keyReg),
      .rdData(kMemRd),
      .allData(kMemAll)
   );

   ace_round u_round (
      .stIn(stReg),
      .keyIn(keyReg),
      .round(round),
      .decrypt(decrypt),
      .stOut(rStOut),
      .keyOut(rKeyOut)
   );

   // bus handshake and read data
   always_comb begin
      next_waitrequest = !((read | write) & waitrequest);
      next_readdata = 32'h0;
      if (acc && read) begin
         case (idx)
            IDX_CTRL: next_readdata[7:0] = {running, autoEn, swRst, decrypt,
                                            1'b0, xorMode, 2'b00};
            IDX_STATUS: next_readdata[7:0] = {errorFlag, 6'h00, doneFlag};
            IDX_STATE: next_readdata[7:0] = running ? 8'h00 : sMemRd;
            IDX_KEY: next_readdata[7:0] = running ? 8'h00 : kMemRd;
            IDX_INTCTRL: next_readdata[7:0] = {6'h00, intLvl};
            default: next_readdata = 32'h0;
         endcase
      end
   end

   // engine control, pointers and run sequencer
   always_comb begin
      next_state = state;
      next_round = round;
      next_cycCnt = cycCnt;
      next_stReg = stReg;
      next_keyReg = keyReg;
      next_kRd = kRd;
      next_kWr = kWr;
      next_sRd = sRd;
      next_sWr = sWr;
      next_accCnt = accCnt;
      next_autoEn = autoEn;
      next_decrypt = decrypt;
      next_xorMode = xorMode;
      next_intLvl = intLvl;
      next_errorFlag = errorFlag;
      next_doneFlag = doneFlag;
      next_swRst = 1'b0;
      next_dmaTrig = 1'b0;
      startReq = 1'b0;
      if (ctrlAcc) begin
         next_kRd = PTR_RST;
         next_kWr = PTR_RST;
         next_sRd = PTR_RST;
         next_sWr = PTR_RST;
         next_accCnt = PTR_RST;
      end
      // 4-bit pointers wrap on their own
      if (stAcc) begin
         next_accCnt = accCnt + 4'h1;
         if (read) begin
            next_sRd = sRd + 4'h1;
            next_doneFlag = 1'b0;
         end else begin
            next_sWr = sWr + 4'h1;
            if (xorMode) begin
               next_sRd = sRd + 4'h1;
            end
            if (autoEn && sWr == 4'hf) begin
               startReq = 1'b1;
            end
         end
      end
      if (keyAcc) begin
         next_accCnt = accCnt + 4'h1;
         if (read) begin
            next_kRd = kRd + 4'h1;
         end else begin
            next_kWr = kWr + 4'h1;
            if (xorMode) begin
               next_kRd = kRd + 4'h1;
            end
         end
      end
      if (wrAcc && idx == IDX_STATUS) begin
         if (writedata[STAT_ERROR]) begin
            next_errorFlag = 1'b0;
         end
         if (writedata[STAT_DONE]) begin
            next_doneFlag = 1'b0;
         end
      end
      if (wrAcc && idx == IDX_INTCTRL) begin
         next_intLvl = writedata[1:0];
      end
      if (wrAcc && idx == IDX_CTRL) begin
         next_autoEn = writedata[CTRL_AUTO];
         next_decrypt = writedata[CTRL_DECRYPT];
         next_xorMode = writedata[CTRL_XOR];
         next_swRst = writedata[CTRL_RESET];
         if (writedata[CTRL_START] && !running) begin
            if (accCnt != 4'h0) begin
               next_errorFlag = 1'b1;
            end else begin
               startReq = 1'b1;
            end
         end
      end
      case (state)
         ST_IDLE: begin
            if (startReq) begin
               next_state = ST_RUN;
               next_cycCnt = 9'h000;
               next_round = 4'h0;
            end
         end
         ST_RUN: begin
            next_cycCnt = cycCnt + 9'h001;
            if (round == 4'h0) begin
               // first key addition is the same in both directions
               next_stReg = sMemAll ^ kMemAll;
               next_keyReg = kMemAll;
               next_round = 4'h1;
            end else if (round <= NUM_ROUNDS) begin
               next_stReg = rStOut;
               next_keyReg = rKeyOut;
               next_round = round + 4'h1;
            end
            if (finish) begin
               next_state = ST_IDLE;
               next_doneFlag = 1'b1;
               next_dmaTrig = 1'b1;
            end
         end
         default: next_state = ST_IDLE;
      endcase
      if (ctrlAcc && running) begin
         next_errorFlag = 1'b1;
         next_state = ST_IDLE;
      end
      if (swRst) begin
         next_state = ST_IDLE;
         next_round = 4'h0;
         next_cycCnt = 9'h000;
         next_stReg = BLOCK_RST;
         next_keyReg = BLOCK_RST;
         next_kRd = PTR_RST;
         next_kWr = PTR_RST;
         next_sRd = PTR_RST;
         next_sWr = PTR_RST;
         next_accCnt = PTR_RST;
         next_autoEn = 1'b0;
         next_decrypt = 1'b0;
         next_xorMode = 1'b0;
         next_intLvl = INTLVL_RST;
         next_errorFlag = 1'b0;
         next_doneFlag = 1'b0;
         next_dmaTrig = 1'b0;
      end
      next_irq = next_doneFlag && (next_intLvl != INTLVL_RST);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         round <= 4'h0;
         cycCnt <= 9'h000;
         stReg <= BLOCK_RST;
         keyReg <= BLOCK_RST;
         kRd <= PTR_RST;
         kWr <= PTR_RST;
         sRd <= PTR_RST;
         sWr <= PTR_RST;
         accCnt <= PTR_RST;
         autoEn <= 1'b0;
         decrypt <= 1'b0;
         xorMode <= 1'b0;
         intLvl <= INTLVL_RST;
         errorFlag <= 1'b0;
         doneFlag <= 1'b0;
         swRst <= 1'b0;
         readdata <= 32'h0;
         waitrequest <= WAIT_RST;
         irq <= 1'b0;
         dmaTrig <= 1'b0;
      end else begin
         state <= next_state;
         round <= next_round;
         cycCnt <= next_cycCnt;
         stReg <= next_stReg;
         keyReg <= next_keyReg;
         kRd <= next_kRd;
         kWr <= next_kWr;
         sRd <= next_sRd;
         sWr <= next_sWr;
         accCnt <= next_accCnt;
         autoEn <= next_autoEn;
         decrypt <= next_decrypt;
         xorMode <= next_xorMode;
         intLvl <= next_intLvl;
         errorFlag <= next_errorFlag;
         doneFlag <= next_doneFlag;
         swRst <= next_swRst;
         readdata <= next_readdata;
         waitrequest <= next_waitrequest;
         irq <= next_irq;
         dmaTrig <= next_dmaTrig;
      end
   end

   // checks
   localparam int RUN_LEN_I = 375;
   logic [9:0] runLen;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         runLen <= 10'h000;
      end else begin
         runLen <= running ? runLen + 10'h001 : 10'h000;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   property p_runLen;
      dmaTrig |-> runLen == RUN_LEN_I;
   endproperty
   a_runLen: assert property (p_runLen) else $error("run length wrong");
   property p_dmaDone;
      dmaTrig |-> doneFlag && $past(running) && !running;
   endproperty
   a_dmaDone: assert property (p_dmaDone) else $error("dma without done");
   property p_irq;
      irq == (doneFlag && intLvl != 2'h0);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");
   property p_ctrlPtr;
      ctrlAcc |=> kRd == 4'h0 && kWr == 4'h0 && sRd == 4'h0 && sWr == 4'h0;
   endproperty
   a_ctrlPtr: assert property (p_ctrlPtr) else $error("pointers kept");
   property p_readInc;
      stAcc && read && !swRst |=> sRd == $past(sRd) + 4'h1 && $stable(sWr);
   endproperty
   a_readInc: assert property (p_readInc) else $error("read ptr stuck");
   property p_xorBoth;
      keyWrite && xorMode && !swRst |=>
         kRd == $past(kRd) + 4'h1 && kWr == $past(kWr) + 4'h1;
   endproperty
   a_xorBoth: assert property (p_xorBoth) else $error("xor ptr error");
   property p_wrap;
      stWrite && sWr == 4'hf && !swRst |=> sWr == 4'h0;
   endproperty
   a_wrap: assert property (p_wrap) else $error("no pointer wrap");
   property p_runLock;
      running && (keyAccRaw || stAccRaw) |=>
         $stable(kRd) && $stable(kWr) && $stable(sRd) && $stable(sWr);
   endproperty
   a_runLock: assert property (p_runLock) else $error("access in run");
   property p_ctrlInRun;
      ctrlAcc && running && !swRst |=> errorFlag && !running;
   endproperty
   a_ctrlInRun: assert property (p_ctrlInRun) else $error("no abort");
   property p_stayRun;
      running && !ctrlAcc && !finish && !swRst |=> running;
   endproperty
   a_stayRun: assert property (p_stayRun) else $error("run dropped");
   property p_auto;
      stWrite && autoEn && sWr == 4'hf && !swRst |=> running;
   endproperty
   a_auto: assert property (p_auto) else $error("auto start missed");
   property p_doneClr;
      stAcc && read && !swRst |=> !doneFlag;
   endproperty
   a_doneClr: assert property (p_doneClr) else $error("done kept");
   property p_writeBack;
      finish && !swRst |=> sMemAll == $past(stReg) && kMemAll == $past(keyReg);
   endproperty
   a_writeBack: assert property (p_writeBack) else $error("no result");
   property p_bus;
      !waitrequest |=> waitrequest;
   endproperty
   a_bus: assert property (p_bus) else $error("ack too long");

   c_enc: cover property (dmaTrig && !decrypt);
   c_dec: cover property (dmaTrig && decrypt);
   c_auto: cover property (stWrite && autoEn && sWr == 4'hf);
   c_abort: cover property (ctrlAcc && running);
endmodule : ace_engine

// File: ace_host.sv
// avalon-mm master standing in for the cpu or dma controller
// assumes the slave drops waitrequest for one cycle per request
`timescale 1ns/1ps
module ace_host (
   input wire logic clk,
   input wire logic waitrequest,
   input wire logic [31:0] readdata,
   output logic [4:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata
);
   initial begin
      address = 5'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   // request held until waitrequest low, then one idle edge
   task automatic xfer(input logic w, input logic [4:0] a,
      input logic [7:0] wd, output logic [7:0] rd);
      address <= a;
      writedata <= {24'h0, wd};
      read <= ~w;
      write <= w;
      // no limit here; if waitrequest stays high, only the bench timeout ends this wait
      do @(posedge clk); while (waitrequest !== 1'b0);
      rd = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
   endtask : xfer
endmodule : ace_host

// File: tb_top.sv
// self-checking bench for ace_engine using known block vectors
// assumes ace_host as the bus master
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [4:0] address;
   logic read, write, waitrequest, irq, dmaTrig;
   logic [31:0] writedata, readdata;
   logic [7:0] d;
   logic [15:0] lfsr = 16'h0041;
   logic [127:0] ra, rb;
   int miscompares = 0, checks_done = 0, cyc = 0, dmaAt = 0, t0 = 0;
   localparam logic [127:0] K0 = 128'h000102030405060708090a0b0c0d0e0f;
   localparam logic [127:0] K10 = 128'h13111d7fe3944a17f307a78b4d2b30c5;
   localparam logic [127:0] PT = 128'h00112233445566778899aabbccddeeff;
   localparam logic [127:0] CT = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
   ace_engine dut (.clk(clk), .sys_rst(sys_rst), .address(address),
      .read(read), .write(write), .writedata(writedata),
      .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq), .dmaTrig(dmaTrig));
   ace_host host (.clk(clk), .waitrequest(waitrequest),
      .readdata(readdata), .address(address), .read(read),
      .write(write), .writedata(writedata));
   always #4 clk = ~clk;
   always @(negedge clk) begin
      cyc++;
      if (dmaTrig === 1'b1) dmaAt = cyc;
      if (cyc > 30000) begin
         miscompares++;
         summarize();
      end
   end
   function automatic logic [15:0] nxt(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : nxt
   task automatic check(input string nm, input logic [8:0] s, e);
      checks_done++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : check
   task automatic x(input logic w, input logic [4:0] a, input logic [7:0] v);
      host.xfer(w, a, v, d);
   endtask : x
   task automatic load(input logic [4:0] a, input logic [127:0] v);
      for (int i = 0; i < 16; i++) begin
         t0 = cyc;
         x(1'b1, a, v[127-8*i -: 8]);
      end
   endtask : load
   task automatic cmp16(input logic [4:0] a, input logic [127:0] v);
      for (int i = 0; i < 16; i++) begin
         x(1'b0, a, 8'h00);
         check("byte", {1'b0, d}, {1'b0, v[127-8*i -: 8]});
      end
   endtask : cmp16
   // a run started by the start bit, or by auto mode when c[6] is set
   task automatic run(input logic [7:0] c, input logic [127:0] k, i, o, ko);
      x(1'b1, 5'h00, c);
      load(5'h0c, k);
      load(5'h08, i);
      if (!c[6]) begin
         t0 = cyc;
         x(1'b1, 5'h00, c | 8'h80);
      end
      x(1'b1, 5'h08, 8'hff);
      x(1'b0, 5'h08, 8'h00);
      check("busy", {1'b0, d}, 9'h000);
      for (int n = 0; n < 200 && d[0] !== 1'b1; n++) x(1'b0, 5'h04, 8'h00);
      check("gap", 9'(dmaAt - t0), 9'h179);
      check("irq", {8'h0, irq}, 9'h001);
      x(1'b0, 5'h00, 8'h00);
      check("ctrl", {1'b0, d}, {1'b0, c});
      cmp16(5'h08, o);
      check("irq", {8'h0, irq}, 9'h000);
      cmp16(5'h0c, ko);
      x(1'b0, 5'h0c, 8'h00);
      check("wrap", {1'b0, d}, {1'b0, ko[127:120]});
      $display("test run %h done", c);
   endtask : run
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int j = 0; j < 6; j++) begin
         x(1'b0, 5'(4 * j), 8'h00);
         check("reset", {1'b0, d}, 9'h000);
      end
      $display("test reset done");
      x(1'b1, 5'h10, 8'h01);
      run(8'h00, K0, PT, CT, K10);
      run(8'h10, K10, CT, PT, K0);
      run(8'h40, K0, PT, CT, K10);
      x(1'b1, 5'h00, 8'h00);
      repeat (5) x(1'b1, 5'h0c, 8'h5a);
      x(1'b1, 5'h00, 8'h80);
      x(1'b0, 5'h04, 8'h00);
      check("error", {1'b0, d}, 9'h080);
      x(1'b1, 5'h04, 8'h80);
      x(1'b0, 5'h04, 8'h00);
      check("error", {1'b0, d}, 9'h000);
      $display("test error done");
      x(1'b1, 5'h00, 8'h00);
      load(5'h0c, K0);
      load(5'h08, PT);
      // first a control read, then a control write of zero, aborts a run
      for (int j = 0; j < 2; j++) begin
         x(1'b1, 5'h04, 8'h80);
         x(1'b1, 5'h00, 8'h80);
         x(j[0], 5'h00, 8'h00);
         check("running", {1'b0, d}, j ? 9'h000 : 9'h080);
         x(1'b0, 5'h04, 8'h00);
         check("abort", {1'b0, d}, 9'h080);
      end
      x(1'b0, 5'h00, 8'h00);
      check("idle", {1'b0, d}, 9'h000);
      x(1'b0, 5'h08, 8'h00);
      check("kept", {1'b0, d}, {1'b0, PT[127:120]});
      $display("test abort done");
      for (int i = 0; i < 16; i++) begin
         lfsr = nxt(lfsr);
         ra[8*i +: 8] = lfsr[7:0];
         lfsr = nxt(lfsr);
         rb[8*i +: 8] = lfsr[15:8];
      end
      x(1'b1, 5'h00, 8'h00);
      load(5'h08, ra);
      x(1'b1, 5'h00, 8'h04);
      load(5'h08, rb);
      x(1'b1, 5'h0c, 8'h00);
      x(1'b1, 5'h08, 8'h00);
      x(1'b0, 5'h08, 8'h00);
      check("xor ptr", {1'b0, d}, {1'b0, ra[119:112] ^ rb[119:112]});
      x(1'b1, 5'h00, 8'h00);
      cmp16(5'h08, ra ^ rb);
      $display("test xor done");
      x(1'b1, 5'h00, 8'h20);
      x(1'b0, 5'h10, 8'h00);
      check("swreset", {1'b0, d}, 9'h000);
      x(1'b0, 5'h08, 8'h00);
      check("swreset", {1'b0, d}, 9'h000);
      $display("test swreset done");
      summarize();
   end
endmodule : tb_top
